// ### cac_pkg.sv
// package for the counter array control and flag block
package cac_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] CAC_CONTROL_OFF   = 12'h000;
	localparam logic [11:0] CAC_ENABLE_OFF    = 12'h004;
	localparam logic [11:0] CAC_COUNT_OFF     = 12'h008;
	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int          CAC_WRAP_BIT      = 7;
	localparam int          CAC_RUN_BIT       = 6;
	localparam int          CAC_MOD_COUNT     = 3;
	localparam logic [7:0]  CAC_CONTROL_RST   = 8'h00;
	localparam logic [7:0]  CAC_ENABLE_RST    = 8'h00;
	localparam logic [15:0] CAC_COUNT_RST     = 16'h0000;
	localparam logic [15:0] CAC_COUNT_MAX     = 16'hffff;
	localparam int          CAC_COUNT_BITS    = 16;
	localparam int          CAC_UNUSED_HI     = 5;
	localparam int          CAC_UNUSED_LO     = 3;
	localparam logic [7:0]  CAC_CTRL_WMASK    = 8'hc7;
	localparam logic [7:0]  CAC_ENA_WMASK     = 8'h87;
	localparam logic [31:0] CAC_RDATA_RST     = 32'h00000000;

	// register select, gray coded
	typedef enum logic [1:0] {
		CAC_SEL_NONE = 2'b00,
		CAC_SEL_CTRL = 2'b01,
		CAC_SEL_ENA  = 2'b11,
		CAC_SEL_CNT  = 2'b10
	} cac_sel_t;

	// event inputs from the module datapaths
	typedef struct packed {
		logic [CAC_MOD_COUNT-1:0] module_event;
		logic                     count_tick;
	} cac_event_t;
endpackage : cac_pkg

// ### cac_top.sv
// counter array run control, counter and event flags with apb access
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - counter advances only while the run bit is one.
// - control bits 5 to 3 read zero and ignore writes.
// - a module event sets its flag in bits 2 to 0.
// - an enabled set flag raises the counter array interrupt request.
// - hardware never clears a module flag, not even on service.
// - counter wrap from ffff to 0000 sets the wrap flag bit 7.
module cac_top #(
	parameter int MOD_COUNT  = cac_pkg::CAC_MOD_COUNT,
	parameter int COUNT_BITS = cac_pkg::CAC_COUNT_BITS
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire cac_pkg::cac_event_t events,
	output logic                     irq,
	output logic      [15:0]         count
);
	import cac_pkg::*;

	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	// module flags must fit below the unused field
	if (MOD_COUNT != CAC_MOD_COUNT || MOD_COUNT < 1
		|| MOD_COUNT > CAC_UNUSED_LO) begin : g_bad_mod
		$error("module count not supported");
	end
	// counter is 16 bits wide, half a 32-bit register word
	if (COUNT_BITS != CAC_COUNT_BITS) begin : g_bad_cnt
		$error("counter width not supported");
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic cac_sel_t decode_sel(input logic [11:0] a);
		cac_sel_t s;
		s = CAC_SEL_NONE;
		case (a)
			CAC_CONTROL_OFF: begin
				s = CAC_SEL_CTRL;
			end
			CAC_ENABLE_OFF: begin
				s = CAC_SEL_ENA;
			end
			CAC_COUNT_OFF: begin
				s = CAC_SEL_CNT;
			end
			default: begin
				s = CAC_SEL_NONE;
			end
		endcase
		return s;
	endfunction : decode_sel

	logic [7:0]  ctrl_r,   ctrl_nxt;
	logic [7:0]  ena_r,    ena_nxt;
	logic [15:0] cnt_r,    cnt_nxt;
	logic [31:0] rdata_r,  rdata_nxt;
	logic        irq_r,    irq_nxt;
	logic        ready_r,  ready_nxt;
	logic        slverr_r, slverr_nxt;
	cac_sel_t    sel;
	logic        setup;
	logic        access;
	logic        wr;
	logic        rd;
	logic        wrap;
	logic [7:0]  hw_set;

	assign sel    = decode_sel(paddr);
	assign setup  = psel && !penable;
	assign access = psel && penable && ready_r;
	assign wr     = access && pwrite;
	assign rd     = setup && !pwrite;

	// ------------------------------------------------------------
	// bus response
	// ------------------------------------------------------------
	// one wait-free access phase after every setup cycle
	always_comb begin
		ready_nxt  = setup;
		slverr_nxt = setup && (sel == CAC_SEL_NONE);
		rdata_nxt  = rdata_r;
		if (rd) begin
			case (sel)
				CAC_SEL_CTRL: begin
					rdata_nxt = {24'h000000, ctrl_r & CAC_CTRL_WMASK};
				end
				CAC_SEL_ENA: begin
					rdata_nxt = {24'h000000, ena_r};
				end
				CAC_SEL_CNT: begin
					rdata_nxt = {16'h0000, cnt_r};
				end
				default: begin
					rdata_nxt = CAC_RDATA_RST;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r  <= 1'b0;
			slverr_r <= 1'b0;
			rdata_r  <= CAC_RDATA_RST;
		end else begin
			ready_r  <= ready_nxt;
			slverr_r <= slverr_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	always_comb begin
		cnt_nxt = cnt_r;
		wrap    = 1'b0;
		if (ctrl_r[CAC_RUN_BIT] && events.count_tick) begin
			cnt_nxt = cnt_r + 16'h0001;
			wrap = (cnt_r == CAC_COUNT_MAX);
		end
		if (wr && sel == CAC_SEL_CNT) begin
			cnt_nxt = pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= CAC_COUNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// flags and enables
	// ------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		ena_nxt  = ena_r;
		hw_set   = 8'h00;
		hw_set[CAC_WRAP_BIT] = wrap;
		hw_set[MOD_COUNT-1:0] = events.module_event;
		if (wr && sel == CAC_SEL_CTRL) begin
			ctrl_nxt = pwdata[7:0] & CAC_CTRL_WMASK;
		end
		if (wr && sel == CAC_SEL_ENA) begin
			ena_nxt = pwdata[7:0] & CAC_ENA_WMASK;
		end
		ctrl_nxt = ctrl_nxt | hw_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CAC_CONTROL_RST;
			ena_r  <= CAC_ENABLE_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			ena_r  <= ena_nxt;
		end
	end

	// ------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------
	always_comb begin
		// enabled set flags raise the request
		irq_nxt = |(ctrl_nxt & ena_nxt & CAC_ENA_WMASK);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata  = rdata_r;
	assign pready  = ready_r;
	assign pslverr = slverr_r;
	assign irq     = irq_r;
	assign count   = cnt_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_run_halt: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_r[CAC_RUN_BIT] && !(wr && sel == CAC_SEL_CNT)
		|=> $stable(cnt_r)) else $error("counter moved while stopped");
	chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[CAC_UNUSED_HI:CAC_UNUSED_LO] == 3'b000)
		else $error("unused control bits set");
	chk_unused_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd && sel == CAC_SEL_CTRL
		|=> prdata[CAC_UNUSED_HI:CAC_UNUSED_LO] == 3'b000)
		else $error("unused control bits read back");
	chk_event_set: assert property (@(posedge pclk) disable iff (!presetn)
		events.module_event[0] |=> ctrl_r[0]) else $error("event flag not set");
	chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
		events.module_event[1] && ena_nxt[1] |=> irq_r)
		else $error("interrupt not raised");
	chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[2] && !wr |=> ctrl_r[2]) else $error("flag dropped by hardware");
	chk_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[CAC_RUN_BIT] && events.count_tick && cnt_r == CAC_COUNT_MAX
		|=> ctrl_r[CAC_WRAP_BIT]) else $error("wrap flag not set");
	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel == CAC_SEL_CTRL && !pwdata[1] && events.module_event[1]
		|=> ctrl_r[1]) else $error("event lost to clear");
	chk_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
		wr && sel == CAC_SEL_CTRL && !pwdata[0] && !events.module_event[0]
		|=> !ctrl_r[0]) else $error("software clear failed");
	chk_ready_access: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready) else $error("no answer in access phase");
	chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && sel == CAC_SEL_NONE |=> pslverr)
		else $error("unmapped access not refused");
endmodule : cac_top
`default_nettype wire

// ### cac_top_test.sv
// self-checking bench for the counter array control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin tests_run++; if ((a)!==(e)) begin fail_count++; \
 $display("wrong value %s exp %h got %h", n, e, a); end end
module cac_top_test;
	import cac_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, irq, err;
	logic [15:0] count;
	cac_event_t  ev = '0;
	int          fail_count = 0, tests_run = 0;
	cac_top cac_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .events(ev),
		.irq(irq), .count(count));
	initial forever #4 pclk = ~pclk;
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata; err = pslverr;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask : xfer
	// one-cycle event pulse, then settle
	task automatic pulse(input logic [3:0] v);
		ev <= v;
		@(posedge pclk) ev <= '0;
		repeat (2) @(posedge pclk);
	endtask : pulse
	task automatic t_reserved;
		xfer(0, CAC_CONTROL_OFF, 0); `CHK("ctl_rst", 32'h0, rd)
		`CHK("ok_err", 1'b0, err)
		xfer(1, CAC_CONTROL_OFF, 32'h38);
		xfer(0, CAC_CONTROL_OFF, 0); `CHK("ctl_rsv", 32'h0, rd)
	endtask : t_reserved
	task automatic t_run;
		xfer(1, CAC_COUNT_OFF, 32'hfffe);
		pulse(4'h1); `CHK("halted", 16'hfffe, count)
		xfer(1, CAC_CONTROL_OFF, 32'h40);
		pulse(4'h1); `CHK("running", 16'hffff, count)
		pulse(4'h1); `CHK("wrapped", 16'h0, count)
		xfer(0, CAC_CONTROL_OFF, 0); `CHK("wrap_flag", 32'hc0, rd)
		xfer(1, CAC_CONTROL_OFF, 0);
	endtask : t_run
	task automatic t_flags;
		xfer(1, CAC_ENABLE_OFF, 32'h1);
		pulse(4'h4); `CHK("irq_masked", 1'b0, irq)
		pulse(4'h2); `CHK("irq_set", 1'b1, irq)
		repeat (20) @(posedge pclk);
		xfer(0, CAC_CONTROL_OFF, 0); `CHK("flags", 32'h3, rd)
		`CHK("irq_held", 1'b1, irq)
		xfer(1, CAC_CONTROL_OFF, 0);
		@(posedge pclk); `CHK("irq_clr", 1'b0, irq)
		xfer(0, CAC_CONTROL_OFF, 0); `CHK("flags_clr", 32'h0, rd)
	endtask : t_flags
	// clear write meets a module event at the access edge
	task automatic t_race;
		psel <= 1; pwrite <= 1; paddr <= CAC_CONTROL_OFF; pwdata <= 0;
		@(posedge pclk);
		penable <= 1; ev <= 4'h4;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 0; penable <= 0; ev <= '0;
		@(posedge pclk);
		xfer(0, CAC_CONTROL_OFF, 0); `CHK("set_wins", 32'h2, rd)
	endtask : t_race
	task automatic t_unmapped;
		xfer(0, 12'h00c, 0); `CHK("slverr", 1'b1, err)
		`CHK("rd_unmap", 32'h0, rd)
		`CHK("ready_idle", 1'b0, pready)
		xfer(1, 12'h00c, 32'hff); `CHK("wr_slverr", 1'b1, err)
		xfer(0, CAC_CONTROL_OFF, 0); `CHK("wr_ignored", 32'h2, rd)
		xfer(1, CAC_CONTROL_OFF, 0);
	endtask : t_unmapped
	task automatic print_verdict;
		if (fail_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		#20000;
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		t_reserved();
		t_run();
		t_flags();
		t_race();
		t_unmapped();
		print_verdict();
	end
endmodule : cac_top_test
`default_nettype wire
